// [hdl/bocr_top.v]
// Purpose: Boost one configuration registers and start sequencer
// Assumes: Avalon-MM slave, 32-bit data, PANEL_RST_N synchronous to SYS_CLK
// Notes: Wait and ramp settings are taken at each phase start; frequency writes act at once
//
// Functional notes
// (R1) Frequency code 0..3 selects 400 kHz, 600 kHz, 800 kHz, 1 MHz switching.
// (R2) Ramp code 0 is 0.5 ms; codes 1..15 are 5 ms steps to 75 ms.
// (R3) Start waits code times 5 ms after panel reset pin rises.
// (R4) Unimplemented upper bits ignore writes and read as zero.
// (R5) Frequency, ramp and wait registers at indices 04h-06h are read/write.
//
// Design decision made here: the Avalon-MM interface to the registers.
`include "bocr_defines.vh"

module bocr_top #(
    parameter UNIT_CYCLES = `BOCR_UNIT_CYCLES
) (
    input wire SYS_CLK,
    input wire SYS_RST,
    input wire [7:0] AVS_ADDRESS,
    input wire AVS_READ,
    input wire AVS_WRITE,
    input wire [31:0] AVS_WRITEDATA,
    input wire [3:0] AVS_BYTEENABLE,
    output reg [31:0] AVS_READDATA,
    output reg AVS_WAITREQUEST,
    input wire PANEL_RST_N,
    output reg BOOST_ONE_START,
    output reg BOOST_ONE_RAMPING,
    output reg BOOST_ONE_READY,
    output reg BOOST_ONE_SWITCH_TICK,
    output reg [1:0] BOOST_ONE_SWITCH_RATE
);

localparam [3:0] ST_IDLE = 4'b0001;
localparam [3:0] ST_WAIT = 4'b0010;
localparam [3:0] ST_RAMP = 4'b0100;
localparam [3:0] ST_RUN = 4'b1000;

// ==========================================================
// Switching periods in clock cycles, rounded down
localparam integer RATE0_CYC = `BOCR_RATE0_CYC;
localparam integer RATE1_CYC = `BOCR_RATE1_CYC;
localparam integer RATE2_CYC = `BOCR_RATE2_CYC;
localparam integer RATE3_CYC = `BOCR_RATE3_CYC;

// ==========================================================
// Decoding helpers
function [7:0] rate_cycles;
    input [1:0] code;
    begin
        case (code)
            2'd0: rate_cycles = RATE0_CYC[7:0]; // (R1)
            2'd1: rate_cycles = RATE1_CYC[7:0];
            2'd2: rate_cycles = RATE2_CYC[7:0];
            default: rate_cycles = RATE3_CYC[7:0];
        endcase
    end
endfunction

function [7:0] step_units;
    input [3:0] code;
    begin
        step_units = {4'h0, code} * `BOCR_UNITS_PER_STEP;
    end
endfunction

// ==========================================================
// Register bank
reg [1:0] boost_one_switch_rate;
reg [3:0] boost_one_ramp_time;
reg [3:0] boost_one_power_on_wait;
reg [3:0] state;
reg pin_q;
wire [7:0] idx;
wire req;
wire wr_take;
wire [3:0] status;

assign idx = {2'b00, AVS_ADDRESS[7:2]};
assign req = AVS_READ | AVS_WRITE;
// Write takes effect only on the edge where waitrequest is seen low
assign wr_take = AVS_WRITE & ~AVS_WAITREQUEST & AVS_BYTEENABLE[0];
assign status = {pin_q, state[3], state[2], state[1]};

always @(posedge SYS_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
        AVS_WAITREQUEST <= 1'b1;
        AVS_READDATA <= 32'h0000_0000;
    end else begin
        // One wait cycle per access, then release
        AVS_WAITREQUEST <= ~(req & AVS_WAITREQUEST);
        if (AVS_READ & AVS_WAITREQUEST) begin
            case (idx)
                `BOCR_IDX_FREQ: AVS_READDATA <= {30'h0000_0000, boost_one_switch_rate}; // (R4)
                `BOCR_IDX_RAMP: AVS_READDATA <= {28'h000_0000, boost_one_ramp_time}; // (R4)
                `BOCR_IDX_WAIT: AVS_READDATA <= {28'h000_0000, boost_one_power_on_wait}; // (R4)
                `BOCR_IDX_STAT: AVS_READDATA <= {28'h000_0000, status};
                default: AVS_READDATA <= 32'h0000_0000;
            endcase
        end
    end
end

always @(posedge SYS_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
        boost_one_switch_rate <= `BOCR_FREQ_RST;
        boost_one_ramp_time <= `BOCR_RAMP_RST;
        boost_one_power_on_wait <= `BOCR_WAIT_RST;
    end else if (wr_take) begin
        // Upper bits are simply not stored
        case (idx)
            `BOCR_IDX_FREQ: boost_one_switch_rate <= AVS_WRITEDATA[`BOCR_FREQ_MSB:0]; // (R5)
            `BOCR_IDX_RAMP: boost_one_ramp_time <= AVS_WRITEDATA[`BOCR_RAMP_MSB:0]; // (R5)
            `BOCR_IDX_WAIT: boost_one_power_on_wait <= AVS_WRITEDATA[`BOCR_WAIT_MSB:0]; // (R5)
            default: ;
        endcase
    end
end

// ==========================================================
// Start sequencer
reg [3:0] next_state;
reg tmr_start;
reg [7:0] tmr_units;
wire tmr_busy;
wire tmr_done;
wire pin_rise;

// Pin already high when reset ends counts as a rise
assign pin_rise = PANEL_RST_N & ~pin_q;

always @* begin
    next_state = state;
    tmr_start = 1'b0;
    tmr_units = 8'h00;
    case (state)
        ST_IDLE: begin
            if (pin_rise) begin
                next_state = ST_WAIT;
                tmr_start = 1'b1;
                tmr_units = step_units(boost_one_power_on_wait); // (R3)
            end
        end
        ST_WAIT: begin
            if (tmr_done) begin
                next_state = ST_RAMP;
                tmr_start = 1'b1;
                if (boost_one_ramp_time == 4'h0) begin
                    tmr_units = `BOCR_RAMP_CODE0_UNITS; // (R2)
                end else begin
                    tmr_units = step_units(boost_one_ramp_time); // (R2)
                end
            end
        end
        ST_RAMP: begin
            if (tmr_done) begin
                next_state = ST_RUN;
            end
        end
        ST_RUN: next_state = ST_RUN;
        default: next_state = ST_IDLE;
    endcase
    // Pin low at any time drops the converter back to idle
    if (!PANEL_RST_N) begin
        next_state = ST_IDLE;
        tmr_start = 1'b0;
    end
end

bocr_timer #(
    .UNIT_CYCLES(UNIT_CYCLES)
) u_timer (
    .clk(SYS_CLK),
    .rst(SYS_RST),
    .start(tmr_start),
    .abort(~PANEL_RST_N),
    .units(tmr_units),
    .busy(tmr_busy),
    .done(tmr_done)
);

always @(posedge SYS_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
        state <= ST_IDLE;
        pin_q <= 1'b0;
        BOOST_ONE_START <= 1'b0;
        BOOST_ONE_RAMPING <= 1'b0;
        BOOST_ONE_READY <= 1'b0;
        BOOST_ONE_SWITCH_RATE <= `BOCR_FREQ_RST;
    end else begin
        state <= next_state;
        pin_q <= PANEL_RST_N;
        BOOST_ONE_START <= next_state[2] | next_state[3];
        BOOST_ONE_RAMPING <= next_state[2];
        BOOST_ONE_READY <= next_state[3];
        BOOST_ONE_SWITCH_RATE <= boost_one_switch_rate; // (R1)
    end
end

// ==========================================================
// Switching tick divider
// Integer divider: 600 kHz comes out slightly fast (41 cycles)
reg [7:0] sw_cnt;

always @(posedge SYS_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
        sw_cnt <= 8'h00;
        BOOST_ONE_SWITCH_TICK <= 1'b0;
    end else if (!(next_state[2] | next_state[3])) begin
        // Gated like the start output, so no tick outlives it
        sw_cnt <= 8'h00;
        BOOST_ONE_SWITCH_TICK <= 1'b0;
    end else if (sw_cnt >= rate_cycles(boost_one_switch_rate) - 8'h01) begin
        sw_cnt <= 8'h00;
        BOOST_ONE_SWITCH_TICK <= 1'b1; // (R1)
    end else begin
        sw_cnt <= sw_cnt + 8'h01;
        BOOST_ONE_SWITCH_TICK <= 1'b0;
    end
end

endmodule // bocr_top

// [inc/bocr_defines.vh]
// Purpose: Constants for the boost one configuration register bank
// Assumes: 25 MHz system clock, Avalon-MM word addressing by byte address
// Notes: Register byte address is four times the register index
`ifndef BOCR_DEFINES_VH
`define BOCR_DEFINES_VH

// ==========================================================
// Register indices and address width
`define BOCR_IDX_FREQ 8'h04
`define BOCR_IDX_RAMP 8'h05
`define BOCR_IDX_WAIT 8'h06
`define BOCR_IDX_STAT 8'h0F
`define BOCR_ADDR_W 8

// ==========================================================
// Field positions and widths
`define BOCR_FREQ_MSB 1
`define BOCR_RAMP_MSB 3
`define BOCR_WAIT_MSB 3
`define BOCR_STAT_WAIT 0
`define BOCR_STAT_RAMP 1
`define BOCR_STAT_RUN 2
`define BOCR_STAT_PIN 3

// ==========================================================
// Reset values
`define BOCR_FREQ_RST 2'h1
`define BOCR_RAMP_RST 4'h0
`define BOCR_WAIT_RST 4'h0

// ==========================================================
// Timing
`define BOCR_CLK_HZ 25000000
`define BOCR_CLK_PERIOD_NS 40
`define BOCR_UNIT_NS 500000
`define BOCR_UNIT_CYCLES (`BOCR_UNIT_NS / `BOCR_CLK_PERIOD_NS)
`define BOCR_STEP_MS 5
`define BOCR_UNITS_PER_STEP 8'd10
`define BOCR_RAMP_CODE0_UNITS 8'd1
`define BOCR_RATE0_HZ 400000
`define BOCR_RATE1_HZ 600000
`define BOCR_RATE2_HZ 800000
`define BOCR_RATE3_HZ 1000000
`define BOCR_RATE0_CYC (`BOCR_CLK_HZ / `BOCR_RATE0_HZ)
`define BOCR_RATE1_CYC (`BOCR_CLK_HZ / `BOCR_RATE1_HZ)
`define BOCR_RATE2_CYC (`BOCR_CLK_HZ / `BOCR_RATE2_HZ)
`define BOCR_RATE3_CYC (`BOCR_CLK_HZ / `BOCR_RATE3_HZ)

`endif

// [hdl/bocr_timer.v]
// Purpose: Counts a number of half-millisecond units, then pulses done
// Assumes: Single clock, start and abort are one-cycle or level requests
// Notes: Zero units completes one cycle after start
`include "bocr_defines.vh"

module bocr_timer #(
    parameter UNIT_CYCLES = `BOCR_UNIT_CYCLES
) (
    input wire clk,
    input wire rst,
    input wire start,
    input wire abort,
    input wire [7:0] units,
    output reg busy,
    output reg done
);

reg [15:0] pre;
reg [7:0] left;

always @(posedge clk or posedge rst) begin
    if (rst) begin
        busy <= 1'b0;
        done <= 1'b0;
        pre <= 16'h0000;
        left <= 8'h00;
    end else if (abort) begin
        busy <= 1'b0;
        done <= 1'b0;
        pre <= 16'h0000;
    end else if (start) begin
        pre <= 16'h0000;
        left <= units;
        busy <= (units != 8'h00);
        done <= (units == 8'h00);
    end else begin
        done <= 1'b0;
        if (busy) begin
            if (pre == UNIT_CYCLES[15:0] - 16'h0001) begin
                pre <= 16'h0000;
                if (left <= 8'h01) begin
                    busy <= 1'b0;
                    done <= 1'b1;
                end else begin
                    left <= left - 8'h01;
                end
            end else begin
                pre <= pre + 16'h0001;
            end
        end
    end
end

endmodule // bocr_timer

// [verification/bocr_top_properties.sv]
// Purpose: Port-level checks for the boost one register bank
// Assumes: One clock, reset active high
// Notes: Tick spacing allows one cycle of slack for the integer divider
module bocr_props (
    input logic SYS_CLK,
    input logic SYS_RST,
    input logic [7:0] AVS_ADDRESS,
    input logic AVS_READ,
    input logic AVS_WRITE,
    input logic [31:0] AVS_WRITEDATA,
    input logic [3:0] AVS_BYTEENABLE,
    input logic [31:0] AVS_READDATA,
    input logic AVS_WAITREQUEST,
    input logic PANEL_RST_N,
    input logic BOOST_ONE_START,
    input logic BOOST_ONE_RAMPING,
    input logic BOOST_ONE_READY,
    input logic BOOST_ONE_SWITCH_TICK,
    input logic [1:0] BOOST_ONE_SWITCH_RATE
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (SYS_RST);
    // ==========================================================
    // Tick spacing helper
    logic [7:0] gap;
    logic seen_tick;
    logic [7:0] per;
    assign per = (BOOST_ONE_SWITCH_RATE == 2'h0) ? 8'h3E : (BOOST_ONE_SWITCH_RATE == 2'h1) ?
                 8'h29 : (BOOST_ONE_SWITCH_RATE == 2'h2) ? 8'h1F : 8'h19;
    always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
        if (SYS_RST || !BOOST_ONE_START) begin
            gap <= 8'h00;
            seen_tick <= 1'b0;
        end else begin
            gap <= BOOST_ONE_SWITCH_TICK ? 8'h00 : gap + 8'h01;
            seen_tick <= seen_tick | BOOST_ONE_SWITCH_TICK;
        end
    end
    // ==========================================================
    // Properties
    sequence one_wait_cycle;
        !AVS_WAITREQUEST ##1 AVS_WAITREQUEST;
    endsequence
    a_bus_one_wait: assert property ((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=> one_wait_cycle)
        else $error("waitrequest not low for exactly one cycle");
    a_upper_read_zero: assert property (AVS_READ && !AVS_WAITREQUEST |-> AVS_READDATA[31:4] == 28'h000_0000)
        else $error("read data above bit 3 not zero");
    a_freq_read_zero: assert property (AVS_READ && !AVS_WAITREQUEST && AVS_ADDRESS == 8'h10
        |-> AVS_READDATA[31:2] == 30'h0000_0000) else $error("frequency read above bit 1 not zero");
    a_rate_copy: assert property (AVS_WRITE && !AVS_WAITREQUEST && AVS_ADDRESS == 8'h10 && AVS_BYTEENABLE[0]
        |-> ##2 BOOST_ONE_SWITCH_RATE == $past(AVS_WRITEDATA[1:0], 2)) else $error("rate output wrong");
    a_tick_period: assert property (BOOST_ONE_SWITCH_TICK && seen_tick |-> gap + 8'h02 >= per && gap <= per)
        else $error("switch tick spacing wrong");
    a_start_ramps: assert property ($rose(BOOST_ONE_START) |-> BOOST_ONE_RAMPING && !BOOST_ONE_READY)
        else $error("start without ramp phase");
    a_ramp_ready: assert property ($fell(BOOST_ONE_RAMPING) && BOOST_ONE_START |-> BOOST_ONE_READY)
        else $error("ramp ended without ready");
    a_pin_stop: assert property (!PANEL_RST_N |=> !BOOST_ONE_START && !BOOST_ONE_READY)
        else $error("converter running while pin low");
    a_tick_in_run: assert property (BOOST_ONE_SWITCH_TICK |-> BOOST_ONE_START)
        else $error("switch tick outside run");
    a_ready_no_ramp: assert property (BOOST_ONE_READY |-> BOOST_ONE_START && !BOOST_ONE_RAMPING)
        else $error("ready while ramping or stopped");
endmodule // bocr_props

bind bocr_top bocr_props u_props (
    .SYS_CLK(SYS_CLK),
    .SYS_RST(SYS_RST),
    .AVS_ADDRESS(AVS_ADDRESS),
    .AVS_READ(AVS_READ),
    .AVS_WRITE(AVS_WRITE),
    .AVS_WRITEDATA(AVS_WRITEDATA),
    .AVS_BYTEENABLE(AVS_BYTEENABLE),
    .AVS_READDATA(AVS_READDATA),
    .AVS_WAITREQUEST(AVS_WAITREQUEST),
    .PANEL_RST_N(PANEL_RST_N),
    .BOOST_ONE_START(BOOST_ONE_START),
    .BOOST_ONE_RAMPING(BOOST_ONE_RAMPING),
    .BOOST_ONE_READY(BOOST_ONE_READY),
    .BOOST_ONE_SWITCH_TICK(BOOST_ONE_SWITCH_TICK),
    .BOOST_ONE_SWITCH_RATE(BOOST_ONE_SWITCH_RATE)
);

// [verification/tb_boost_one_config_regs.sv]
// Purpose: Register and start sequence test of the boost one bank
// Assumes: UNIT_CYCLES of 10, so one 5 ms step is 100 cycles
// Notes: Phase lengths are judged with three cycles of slack
module tb_boost_one_config_regs;
    timeunit 1ns;
    timeprecision 1ps;
    logic SYS_CLK = 1'b0;
    logic SYS_RST = 1'b1;
    logic AVS_READ = 1'b0;
    logic AVS_WRITE = 1'b0;
    logic PANEL_RST_N = 1'b0;
    logic [7:0] AVS_ADDRESS = 8'h00;
    logic [31:0] AVS_WRITEDATA = 32'h0000_0000;
    logic [3:0] AVS_BYTEENABLE = 4'h1;
    logic [31:0] AVS_READDATA;
    logic AVS_WAITREQUEST, BOOST_ONE_START, BOOST_ONE_RAMPING, BOOST_ONE_READY;
    logic BOOST_ONE_SWITCH_TICK;
    logic [1:0] BOOST_ONE_SWITCH_RATE;
    int fail_count = 0;
    int tests_run = 0;
    int n;
    logic [31:0] rd;
    always #20 SYS_CLK = ~SYS_CLK;
    bocr_top #(
        .UNIT_CYCLES(10)
    ) dut_u (
        .SYS_CLK(SYS_CLK),
        .SYS_RST(SYS_RST),
        .AVS_ADDRESS(AVS_ADDRESS),
        .AVS_READ(AVS_READ),
        .AVS_WRITE(AVS_WRITE),
        .AVS_WRITEDATA(AVS_WRITEDATA),
        .AVS_BYTEENABLE(AVS_BYTEENABLE),
        .AVS_READDATA(AVS_READDATA),
        .AVS_WAITREQUEST(AVS_WAITREQUEST),
        .PANEL_RST_N(PANEL_RST_N),
        .BOOST_ONE_START(BOOST_ONE_START),
        .BOOST_ONE_RAMPING(BOOST_ONE_RAMPING),
        .BOOST_ONE_READY(BOOST_ONE_READY),
        .BOOST_ONE_SWITCH_TICK(BOOST_ONE_SWITCH_TICK),
        .BOOST_ONE_SWITCH_RATE(BOOST_ONE_SWITCH_RATE)
    );
    // ==========================================================
    // Tasks
    task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic bus(logic wr, logic [7:0] a, logic [31:0] d);
        @(posedge SYS_CLK);
        AVS_ADDRESS <= a;
        AVS_WRITEDATA <= d;
        AVS_WRITE <= wr;
        AVS_READ <= !wr;
        @(posedge SYS_CLK);
        while (AVS_WAITREQUEST) @(posedge SYS_CLK);
        rd = AVS_READDATA;
        AVS_WRITE <= 1'b0;
        AVS_READ <= 1'b0;
    endtask
    task automatic span(logic rdy, int exp);
        n = 0;
        while ((rdy ? BOOST_ONE_READY : BOOST_ONE_START) !== 1'b1 && n < 3000) begin
            @(posedge SYS_CLK);
            n++;
        end
        check("phase length", 32'(n >= exp - 3 && n <= exp + 3), 32'h0000_0001);
    endtask
    task automatic phase(logic [3:0] w, logic [3:0] r);
        bus(1'b1, 8'h18, {28'h000_0000, w});
        bus(1'b1, 8'h14, {28'h000_0000, r});
        PANEL_RST_N <= 1'b0;
        @(posedge SYS_CLK);
        PANEL_RST_N <= 1'b1;
        @(posedge SYS_CLK);
        span(1'b0, (w == 4'h0) ? 1 : 100 * w);
        check("ramping", {31'h0000_0000, BOOST_ONE_RAMPING}, 32'h0000_0001);
        span(1'b1, (r == 4'h0) ? 10 : 100 * r);
        check("ramp end", {31'h0000_0000, BOOST_ONE_RAMPING}, 32'h0000_0000);
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // ==========================================================
    // Sequence
    initial begin
        repeat (8) @(posedge SYS_CLK);
        SYS_RST <= 1'b0;
        bus(1'b0, 8'h10, 32'h0000_0000);
        check("freq reset", rd, 32'h0000_0001);
        for (n = 0; n < 3; n++) begin
            bus(1'b1, 8'h10 + 8'(4 * n), 32'hFFFF_FFFF);
            bus(1'b0, 8'h10 + 8'(4 * n), 32'h0000_0000);
            check("upper bits", rd, (n == 0) ? 32'h0000_0003 : 32'h0000_000F);
        end
        bus(1'b1, 8'h20, 32'hFFFF_FFFF);
        bus(1'b0, 8'h20, 32'h0000_0000);
        check("unmapped", rd, 32'h0000_0000);
        for (n = 0; n < 4; n++) begin
            bus(1'b1, 8'h10, 32'(n));
            bus(1'b0, 8'h10, 32'h0000_0000);
            check("freq code", rd, 32'(n));
            check("rate out", {30'h0000_0000, BOOST_ONE_SWITCH_RATE}, 32'(n));
        end
        AVS_BYTEENABLE <= 4'h0;
        bus(1'b1, 8'h10, 32'h0000_0000);
        AVS_BYTEENABLE <= 4'h1;
        bus(1'b0, 8'h10, 32'h0000_0000);
        check("lane off", rd, 32'h0000_0003);
        phase(4'h1, 4'h0);
        phase(4'h0, 4'h1);
        phase(4'hF, 4'hF);
        bus(1'b0, 8'h3C, 32'h0000_0000);
        check("status", rd, 32'h0000_000C);
        // Rate code 3: one tick per 25 cycles
        n = 0;
        repeat (100) begin
            @(posedge SYS_CLK);
            n += int'(BOOST_ONE_SWITCH_TICK);
        end
        check("tick count", 32'(n), 32'h0000_0004);
        PANEL_RST_N <= 1'b0;
        repeat (2) @(posedge SYS_CLK);
        check("stopped", {31'h0000_0000, BOOST_ONE_START}, 32'h0000_0000);
        tally_and_finish();
    end
    initial begin
        repeat (20000) @(posedge SYS_CLK);
        fail_count++;
        tally_and_finish();
    end
endmodule // tb_boost_one_config_regs
